// ==== common/loader_pkg.sv ====
package loader_pkg;

    // byte values on the wire
    localparam logic [7:0] SYNC_BYTE       = 8'h55;
    localparam logic [7:0] ACK_BYTE        = 8'hCC;
    localparam logic [7:0] NAK_BYTE        = 8'h33;
    localparam logic [7:0] ZERO_BYTE       = 8'h00;
    localparam logic [7:0] CMD_PING        = 8'h20;
    localparam logic [7:0] CMD_STATUS_QRY  = 8'h23;
    localparam logic [7:0] MIN_PKT_LEN     = 8'h03;
    localparam logic [7:0] STATUS_PKT_LEN  = 8'h03;

    // last-command status codes
    localparam logic [7:0] STAT_SUCCESS    = 8'h40;
    localparam logic [7:0] STAT_UNKNOWN    = 8'h41;
    localparam logic [7:0] STAT_RESET      = 8'h40;

    // character format
    localparam int         DATA_BITS       = 8;
    localparam int         STOP_BITS       = 1;
    localparam int         SYNC_EDGES      = 8;

    // auto-baud timing
    localparam logic [15:0] BAUD_MIN_HALF  = 16'h0010;
    localparam logic [15:0] BAUD_CNT_MAX   = 16'hFFFF;

    // payload store
    localparam int         BUF_AW          = 8;
    localparam int         BUF_DW          = 8;

    // port lock
    typedef enum logic [2:0]
    {
        PORT_NONE  = 3'b001,
        PORT_ASYNC = 3'b010,
        PORT_SYNC  = 3'b100
    } port_t;

    // packet engine states
    typedef enum logic [7:0]
    {
        PK_LEN     = 8'b0000_0001,
        PK_SUM     = 8'b0000_0010,
        PK_DATA    = 8'b0000_0100,
        PK_REPLY   = 8'b0000_1000,
        PK_TX_LEN  = 8'b0001_0000,
        PK_TX_SUM  = 8'b0010_0000,
        PK_TX_DAT  = 8'b0100_0000,
        PK_TX_WAIT = 8'b1000_0000
    } pkt_t;

    // auto-baud states
    typedef enum logic [3:0]
    {
        AB_IDLE  = 4'b0001,
        AB_MEAS  = 4'b0010,
        AB_ACK   = 4'b0100,
        AB_RUN   = 4'b1000
    } baud_t;

endpackage

// ==== src/payload_ram.sv ====
`timescale 1ns/1ps
// small payload store, registered read
module payload_ram
    import loader_pkg::*;
(
    // clock
    input  wire logic              clk,
    // write side
    input  wire logic              wr_en,
    input  wire logic [BUF_AW-1:0] wr_addr,
    input  wire logic [BUF_DW-1:0] wr_data,
    // read side
    input  wire logic [BUF_AW-1:0] rd_addr,
    output logic      [BUF_DW-1:0] rd_data
);

    logic [BUF_DW-1:0] mem [0:(1<<BUF_AW)-1];

    // no reset on storage; rd_addr is read every clock, written or not
    always_ff @(posedge clk)
    begin
        if (wr_en)
            mem[wr_addr] <= wr_data;
        rd_data <= mem[rd_addr];
    end

endmodule

// ==== src/serial_loader.sv ====
`timescale 1ns/1ps
// Summary of operation
// R1 - first working port locks out the other
// R2 - async frames: 8 data, no parity, 1 stop
// R3 - host keeps baud at most clock/32
// R4 - two 0x55 bytes set the baud divisor
// R5 - send 0xCC after baud detected
// R6 - host resends sync when 0xCC missing
// R7 - sync port is mode 3 slave
// R8 - host supplies sync clock, at most clock/12
// R9 - packets everywhere, each answered ack/nak
// R10 - length byte, then checksum, then payload
// R11 - checksum sums payload bytes only
// R12 - payload holds length minus two bytes
// R13 - reply 0xCC good, 0x33 bad
// R14 - ack means received, not command success
// R15 - optional leading zeros, then no gaps
// R16 - host acks or naks device packets
// R17 - host resends command after its nak
// R18 - device ignores zeros awaiting host answer
// R19 - first payload byte is the command
// R20 - ping sets status to success
// R21 - status query returns one-byte status packet
// R22 - host queries status after each command
// R23 - eight-bit sum; nak if bad or short
// R24 - status byte persists until next command
module serial_loader
    import loader_pkg::*;
(
    // clock and reset
    input  wire logic       CLK_SYS,
    input  wire logic       RST_N,
    // async serial port
    input  wire logic       ASYNC_RXD,
    output logic            ASYNC_TXD,
    // sync serial port, mode 3 slave
    input  wire logic       SYNC_SCLK,
    input  wire logic       SYNC_CS_N,
    input  wire logic       SYNC_MOSI,
    output logic            SYNC_MISO,
    output logic            SYNC_MISO_OE,
    // status
    output logic [7:0]      LAST_STATUS,
    output logic [1:0]      PORT_LOCK
);

    // ---------------- input edges (pins taken as synchronous)
    logic sclk_q, rxd_q;
    logic sclk_rise, sclk_fall, rxd_fall, rxd_edge;

    always_comb
    begin
        sclk_rise = SYNC_SCLK & ~sclk_q & ~SYNC_CS_N;
        sclk_fall = ~SYNC_SCLK & sclk_q & ~SYNC_CS_N;
        rxd_fall  = ~ASYNC_RXD & rxd_q;
        rxd_edge  = ASYNC_RXD ^ rxd_q;
    end

    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            sclk_q <= 1'b1;
            rxd_q  <= 1'b1;
        end
        else
        begin
            sclk_q <= SYNC_SCLK;
            rxd_q  <= ASYNC_RXD;
        end
    end

    // ---------------- port lock
    port_t port_q, port_d;
    logic  pkt_done;            // a packet was answered
    logic  from_async_q, from_async_d;

    // ---------------- sync port shifter, sample on rise, drive on fall
    logic [2:0] sbit_q, sbit_d;
    logic [7:0] srx_q, srx_d, stx_q, stx_d;
    logic       s_byte;          // byte complete this cycle
    logic [7:0] s_rx_byte;
    logic       s_load;
    logic [7:0] s_load_byte;
    logic       miso_q, miso_d;
    logic       oe_q, oe_d;      // miso enable, registered so the pin comes from a flop

    always_comb
    begin
        sbit_d    = sbit_q;
        srx_d     = srx_q;
        stx_d     = stx_q;
        miso_d    = miso_q;
        s_byte    = 1'b0;
        s_rx_byte = {srx_q[6:0], SYNC_MOSI};
        oe_d      = ~SYNC_CS_N & (port_q != PORT_ASYNC); // R1
        if (SYNC_CS_N)
        begin
            sbit_d = 3'h0;
            miso_d = stx_q[7];
        end
        else if (sclk_rise && port_q != PORT_ASYNC) // R1 R7
        begin
            srx_d  = s_rx_byte;
            sbit_d = sbit_q + 3'h1;
            stx_d  = {stx_q[6:0], 1'b0};
            s_byte = (sbit_q == 3'h7);
        end
        else if (sclk_fall)
            miso_d = stx_q[7];     // R7
        if (s_load)
            stx_d = s_load_byte;   // R18 zero when idle
    end

    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            sbit_q <= 3'h0;
            srx_q  <= 8'h00;
            stx_q  <= 8'h00;
            miso_q <= 1'b0;
            oe_q   <= 1'b0;
        end
        else
        begin
            sbit_q <= sbit_d;
            srx_q  <= srx_d;
            stx_q  <= stx_d;
            miso_q <= miso_d;
            oe_q   <= oe_d;
        end
    end

    // ---------------- async port: auto-baud, rx, tx
    baud_t      ab_q, ab_d;
    logic [15:0] cnt_q, cnt_d;     // edge timer
    logic [19:0] acc_q, acc_d;     // sum of bit times
    logic [3:0]  edges_q, edges_d;
    logic [15:0] div_q, div_d;     // bit period in clocks
    logic [15:0] rcnt_q, rcnt_d;
    logic [3:0]  rbit_q, rbit_d;
    logic [7:0]  rsh_q, rsh_d;
    logic        rbusy_q, rbusy_d;
    logic        a_byte;
    logic [15:0] tcnt_q, tcnt_d;
    logic [3:0]  tbit_q, tbit_d;
    logic [9:0]  tsh_q, tsh_d;
    logic        txd_q, txd_d;
    logic        a_load;
    logic [7:0]  a_load_byte;
    logic        tx_idle;

    always_comb
    begin
        ab_d = ab_q; cnt_d = cnt_q; acc_d = acc_q; edges_d = edges_q; div_d = div_q;
        rcnt_d = rcnt_q; rbit_d = rbit_q; rsh_d = rsh_q; rbusy_d = rbusy_q; a_byte = 1'b0;
        tcnt_d = tcnt_q; tbit_d = tbit_q; tsh_d = tsh_q; txd_d = txd_q;
        tx_idle = (tbit_q == 4'h0);
        case (ab_q)
            AB_IDLE:
                if (rxd_fall && port_q != PORT_SYNC) // R1
                begin
                    ab_d = AB_MEAS; cnt_d = 16'h0000; acc_d = 20'h00000; edges_d = 4'h0;
                end
            AB_MEAS:   // 0x55 gives one bit per edge; time 8 bit periods
            begin
                cnt_d = cnt_q + 16'h0001;
                if (cnt_q == BAUD_CNT_MAX)
                    ab_d = AB_IDLE;
                else if (rxd_edge)
                begin
                    acc_d   = acc_q + {4'h0, cnt_q} + 20'h00001;
                    cnt_d   = 16'h0000;
                    edges_d = edges_q + 4'h1;
                    if (edges_q == 4'(SYNC_EDGES - 1))
                    begin
                        ab_d  = AB_ACK;  // R4
                        div_d = acc_d[18:3];
                    end
                end
            end
            AB_ACK:    // wait second sync byte to finish, then 0xCC
            begin
                cnt_d = cnt_q + 16'h0001;
                if (cnt_q == {div_q[14:0], 1'b0} + div_q + div_q + div_q + div_q + div_q + div_q
                    + div_q + div_q + div_q + div_q)
                begin
                    ab_d = AB_RUN;
                    tsh_d = {1'b1, ACK_BYTE, 1'b0}; tbit_d = 4'hA; tcnt_d = 16'h0000; // R5
                end
            end
            AB_RUN:
            begin
                // receiver, centre sampling
                if (!rbusy_q)
                begin
                    if (rxd_fall)
                    begin
                        rbusy_d = 1'b1; rcnt_d = {1'b0, div_q[15:1]}; rbit_d = 4'h0;
                    end
                end
                else if (rcnt_q == 16'h0000)
                begin
                    rcnt_d = div_q - 16'h0001;
                    rbit_d = rbit_q + 4'h1;
                    if (rbit_q >= 4'h1 && rbit_q <= 4'(DATA_BITS))
                        rsh_d = {rxd_q, rsh_q[7:1]};     // R2 lsb first
                    if (rbit_q == 4'(DATA_BITS + STOP_BITS))
                    begin
                        rbusy_d = 1'b0;
                        a_byte  = rxd_q;               // R2 bad stop dropped
                    end
                end
                else
                    rcnt_d = rcnt_q - 16'h0001;
            end
            default: ab_d = AB_IDLE;
        endcase
        // transmitter
        if (tbit_q != 4'h0)
        begin
            txd_d = tsh_q[0];
            if (tcnt_q == div_q - 16'h0001)
            begin
                tcnt_d = 16'h0000; tsh_d = {1'b1, tsh_q[9:1]}; tbit_d = tbit_q - 4'h1;
            end
            else
                tcnt_d = tcnt_q + 16'h0001;
        end
        else
            txd_d = 1'b1;
        if (a_load)
        begin
            tsh_d = {1'b1, a_load_byte, 1'b0}; tbit_d = 4'hA; tcnt_d = 16'h0000; // R2
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ab_q <= AB_IDLE; cnt_q <= 16'h0000; acc_q <= 20'h00000; edges_q <= 4'h0;
            div_q <= BAUD_MIN_HALF; rcnt_q <= 16'h0000; rbit_q <= 4'h0; rsh_q <= 8'h00;
            rbusy_q <= 1'b0; tcnt_q <= 16'h0000; tbit_q <= 4'h0; tsh_q <= 10'h3FF; txd_q <= 1'b1;
        end
        else
        begin
            ab_q <= ab_d; cnt_q <= cnt_d; acc_q <= acc_d; edges_q <= edges_d; div_q <= div_d;
            rcnt_q <= rcnt_d; rbit_q <= rbit_d; rsh_q <= rsh_d; rbusy_q <= rbusy_d;
            tcnt_q <= tcnt_d; tbit_q <= tbit_d; tsh_q <= tsh_d; txd_q <= txd_d;
        end
    end

    // ---------------- packet engine
    pkt_t       pk_q, pk_d;
    logic [7:0] len_q, len_d, sum_q, sum_d, calc_q, calc_d, idx_q, idx_d, cmd_q, cmd_d;
    logic [7:0] stat_q, stat_d;
    logic       rx_ok;
    logic [7:0] rx_byte;
    logic       wr_en;
    logic [7:0] ram_rd;
    logic       slot;            // a byte slot is free to send
    logic [7:0] tx_byte;
    logic       tx_go;

    payload_ram u_ram
    (
        .clk     (CLK_SYS),
        .wr_en   (wr_en),
        .wr_addr (idx_q),
        .wr_data (rx_byte),
        .rd_addr (8'h00),
        .rd_data (ram_rd)
    );

    always_comb
    begin
        rx_ok   = (s_byte && port_q != PORT_ASYNC) || (a_byte && port_q != PORT_SYNC); // R1
        rx_byte = s_byte ? s_rx_byte : rsh_d;
        slot    = from_async_q ? tx_idle : s_byte;   // a_load follows slot, never feeds it
        pk_d = pk_q; len_d = len_q; sum_d = sum_q; calc_d = calc_q; idx_d = idx_q; cmd_d = cmd_q;
        stat_d = stat_q; from_async_d = from_async_q; pkt_done = 1'b0;
        wr_en = 1'b0; tx_go = 1'b0; tx_byte = ZERO_BYTE;
        case (pk_q)
            PK_LEN:
                if (rx_ok && rx_byte != ZERO_BYTE) // R10 leading zeros skipped
                begin
                    len_d = rx_byte; calc_d = 8'h00; idx_d = 8'h00;
                    from_async_d = a_byte;
                    pk_d = PK_SUM;
                end
            PK_SUM:
                if (rx_ok)
                begin
                    sum_d = rx_byte;                                   // R10
                    pk_d  = (len_q < MIN_PKT_LEN) ? PK_REPLY : PK_DATA; // R23
                end
            PK_DATA:
                if (rx_ok)
                begin
                    calc_d = calc_q + rx_byte;   // R11 R23 wraps mod 256
                    wr_en  = 1'b1;
                    if (idx_q == 8'h00)
                        cmd_d = rx_byte;         // R19
                    idx_d = idx_q + 8'h01;
                    if (idx_q == len_q - 8'h03)  // R12
                        pk_d = PK_REPLY;
                end
            PK_REPLY:
                if (slot)
                begin
                    tx_go = 1'b1;
                    pkt_done = 1'b1;                                  // R9
                    if (len_q >= MIN_PKT_LEN && calc_q == sum_q) // R13 R14
                    begin
                        tx_byte = ACK_BYTE;
                        if (cmd_q == CMD_PING)
                            stat_d = STAT_SUCCESS;                    // R20
                        else if (cmd_q != CMD_STATUS_QRY)
                            stat_d = STAT_UNKNOWN;                    // R24
                        pk_d = (cmd_q == CMD_STATUS_QRY) ? PK_TX_LEN : PK_LEN; // R21
                    end
                    else
                    begin
                        tx_byte = NAK_BYTE;                           // R13
                        pk_d = PK_LEN;
                    end
                end
            PK_TX_LEN:   // status packet back to back, no gaps
                if (slot)
                begin
                    tx_go = 1'b1; tx_byte = STATUS_PKT_LEN; pk_d = PK_TX_SUM; // R15
                end
            PK_TX_SUM:
                if (slot)
                begin
                    tx_go = 1'b1; tx_byte = stat_q; pk_d = PK_TX_DAT;        // R11
                end
            PK_TX_DAT:
                if (slot)
                begin
                    tx_go = 1'b1; tx_byte = stat_q; pk_d = PK_TX_WAIT;       // R21
                end
            PK_TX_WAIT:  // host answer; zeros ignored, any nonzero closes
                if (rx_ok && rx_byte != ZERO_BYTE)                          // R18
                    pk_d = PK_LEN;
            default: pk_d = PK_LEN;
        endcase
        a_load      = tx_go && from_async_q;
        a_load_byte = tx_byte;
        s_load      = s_byte && port_q != PORT_ASYNC;  // refill every byte, zero if nothing
        s_load_byte = (tx_go && !from_async_q) ? tx_byte : ZERO_BYTE;
        port_d = port_q;
        if (pkt_done && port_q == PORT_NONE)
            port_d = from_async_q ? PORT_ASYNC : PORT_SYNC; // R1
    end

    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            pk_q <= PK_LEN; len_q <= 8'h00; sum_q <= 8'h00; calc_q <= 8'h00; idx_q <= 8'h00;
            cmd_q <= 8'h00; stat_q <= STAT_RESET; from_async_q <= 1'b0; port_q <= PORT_NONE;
        end
        else
        begin
            pk_q <= pk_d; len_q <= len_d; sum_q <= sum_d; calc_q <= calc_d; idx_q <= idx_d;
            cmd_q <= cmd_d; stat_q <= stat_d; from_async_q <= from_async_d; port_q <= port_d;
        end
    end

    // ---------------- outputs, all from flops
    always_comb
    begin
        ASYNC_TXD    = txd_q;
        SYNC_MISO    = miso_q;
        SYNC_MISO_OE = oe_q;          // lags the select by one clock
        LAST_STATUS  = stat_q;
        PORT_LOCK    = port_q[2:1];   // one-hot lock bits: sync, async
    end

    // ---------------- checks
    sequence ack_sent_s;
        pk_q == PK_REPLY && tx_go && tx_byte == ACK_BYTE;
    endsequence

    lock_stays_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        port_q != PORT_NONE |=> port_q == $past(port_q)) // R1
        else $error("port lock changed");
    ping_status_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        ack_sent_s and cmd_q == CMD_PING |=> stat_q == STAT_SUCCESS) // R20
        else $error("ping did not set success");
    nak_bad_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        pk_q == PK_REPLY && tx_go && calc_q != sum_q |-> tx_byte == NAK_BYTE) // R23
        else $error("bad checksum acked");
    short_nak_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        pk_q == PK_SUM && rx_ok && len_q < MIN_PKT_LEN |=> pk_q == PK_REPLY) // R23
        else $error("short packet not naked");
    query_reply_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        ack_sent_s and cmd_q == CMD_STATUS_QRY |=> pk_q == PK_TX_LEN) // R21
        else $error("status query gave no packet");
    status_hold_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        pk_q != PK_REPLY |=> $stable(stat_q)) // R24
        else $error("status changed outside reply");
    baud_ack_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        ab_q == AB_ACK && ab_d == AB_RUN |=> tsh_q[8:1] == ACK_BYTE && tbit_q == 4'hA) // R5
        else $error("0xCC not sent after sync");
    zero_ignore_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        pk_q == PK_TX_WAIT && rx_ok && rx_byte == ZERO_BYTE |=> pk_q == PK_TX_WAIT) // R18
        else $error("zero taken as answer");

endmodule

// ==== verification/host_model.sv ====
`timescale 1ns/1ps
// serial host: uart talker and mode 3 spi master
module host_model
#(
    parameter int BIT_CLKS = 40
)
(
    // clock
    input  wire logic       clk,
    // uart lines
    output logic            rxd,
    input  wire logic       txd,
    // spi lines
    output logic            sclk,
    output logic            cs_n,
    output logic            mosi,
    input  wire logic       miso,
    input  wire logic       miso_oe,
    // bytes seen from the device; the spi side drops zeros, the uart side reports them
    output logic [7:0]      got_byte,
    output logic            got_stb,
    output logic            oe_seen
);
    logic miso_last;
    logic miso_wire;

    // released wire toggles so a stale level never reads as data
    assign miso_wire = miso_oe ? miso : ~miso_last;

    always @(posedge clk) miso_last <= miso_wire;

    // idle levels: uart mark, spi clock high, deselected
    initial
    begin
        rxd = 1'b1;
        sclk = 1'b1;
        cs_n = 1'b1;
        mosi = 1'b0;
        got_byte = 8'h00;
        got_stb = 1'b0;
        oe_seen = 1'b0;
        miso_last = 1'b0;
    end

    // one-cycle strobe per received byte
    task automatic report(input logic [7:0] b);
        @(negedge clk);
        got_byte = b;
        got_stb = 1'b1;
        @(negedge clk);
        got_stb = 1'b0;
    endtask

    // 8N1, lsb first; BIT_CLKS stays at or above 32 clocks
    task automatic uart_byte(input logic [7:0] b);
        @(negedge clk);
        rxd = 1'b0;
        repeat (BIT_CLKS) @(negedge clk);
        for (int i = 0; i < 8; i++)
        begin
            rxd = b[i];
            repeat (BIT_CLKS) @(negedge clk);
        end
        rxd = 1'b1;
        repeat (BIT_CLKS) @(negedge clk);
    endtask

    // one spi byte, msb first, clock period 16 system clocks
    task automatic spi_byte(input logic [7:0] tx);
        logic [7:0] rx;
        rx = 8'h00;
        oe_seen = 1'b0;
        @(negedge clk);
        cs_n = 1'b0;
        repeat (4) @(negedge clk);
        for (int i = 7; i >= 0; i--)
        begin
            sclk = 1'b0;
            mosi = tx[i];
            repeat (8) @(negedge clk);
            sclk = 1'b1;
            rx = {rx[6:0], miso_wire};
            oe_seen = oe_seen | miso_oe;
            repeat (8) @(negedge clk);
        end
        cs_n = 1'b1;
        mosi = ~mosi;
        repeat (4) @(negedge clk);
        // zeros are padding; a floating line is not data
        if (oe_seen && rx != 8'h00)
            report(rx);
    endtask

    // uart receiver, samples mid-bit, drops frames with a bad stop
    always
    begin : rx_proc
        logic [7:0] b;
        @(negedge txd);
        repeat (BIT_CLKS / 2) @(posedge clk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT_CLKS) @(posedge clk);
            b[i] = txd;
        end
        repeat (BIT_CLKS) @(posedge clk);
        if (txd === 1'b1)
            report(b);
    end
endmodule

// ==== verification/tb.sv ====
`timescale 1ns/1ps
module tb;
    import loader_pkg::*;
    typedef logic [7:0] bytes_t[$];
    localparam int BIT_CLKS = 40;
    logic       clk_sys;
    logic       rst_n;
    logic       rxd;
    logic       txd;
    logic       sclk;
    logic       cs_n;
    logic       mosi;
    logic       miso;
    logic       miso_oe;
    logic [7:0] status;
    logic [1:0] lock;
    logic [7:0] got_byte;
    logic       got_stb;
    logic       oe_seen;
    logic [7:0] exp_q[$];
    int         bad_count;
    int         tests_run;
    int         seed;
    bit         use_spi;

    serial_loader u_dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .ASYNC_RXD(rxd), .ASYNC_TXD(txd),
        .SYNC_SCLK(sclk), .SYNC_CS_N(cs_n), .SYNC_MOSI(mosi), .SYNC_MISO(miso),
        .SYNC_MISO_OE(miso_oe), .LAST_STATUS(status), .PORT_LOCK(lock));

    host_model #(.BIT_CLKS(BIT_CLKS)) u_host (.clk(clk_sys), .rxd(rxd), .txd(txd), .sclk(sclk),
        .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .got_byte(got_byte),
        .got_stb(got_stb), .oe_seen(oe_seen));

    // 25 MHz system clock
    initial clk_sys = 1'b0;
    always #20 clk_sys = ~clk_sys;

    task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // each byte from the device retires the oldest note
    always @(posedge clk_sys)
    begin
        if (got_stb === 1'b1)
        begin
            if (exp_q.size() == 0)
                cmp8("unexpected byte", ZERO_BYTE, got_byte);
            else
                cmp8("device byte", exp_q.pop_front(), got_byte);
        end
    end

    task automatic do_reset();
        @(negedge clk_sys);
        rst_n = 1'b0;
        repeat (16) @(negedge clk_sys);
        cmp8("txd idle", 8'h01, {7'h00, txd});
        cmp8("status at reset", STAT_RESET, status);
        cmp8("lock at reset", 8'h00, {6'h00, lock});
        rst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
    endtask

    task automatic put(input logic [7:0] b);
        if (use_spi)
            u_host.spi_byte(b);
        else
            u_host.uart_byte(b);
    endtask

    task automatic send_raw(input bytes_t b);
        foreach (b[i])
            put(b[i]);
    endtask

    // length counts itself and the sum; sum wraps at eight bits
    task automatic send_pkt(input bytes_t pl);
        logic [7:0] sum;
        sum = 8'h00;
        foreach (pl[i])
            sum = sum + pl[i];
        pl.push_front(sum);
        pl.push_front(8'(pl.size() + 1));
        send_raw(pl);
    endtask

    // bounded wait; spi needs zero padding to clock replies out
    task automatic drain();
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 20000)
        begin
            if (use_spi)
            begin
                u_host.spi_byte(ZERO_BYTE);
                n = n + 200;
            end
            else
            begin
                @(negedge clk_sys);
                n++;
            end
        end
        if (exp_q.size() != 0)
        begin
            cmp8("missing reply", exp_q[0], ZERO_BYTE);
            exp_q.delete();
        end
        repeat (3 * BIT_CLKS) @(negedge clk_sys);
    endtask

    task automatic ping();
        exp_q.push_back(ACK_BYTE);
        send_pkt({CMD_PING});
        drain();
        cmp8("status after ping", STAT_SUCCESS, status);
    endtask

    // random command other than ping and query, random parameters
    task automatic other_cmd();
        bytes_t pl;
        pl = {8'(8'h24 + ($random(seed) & 7))};
        repeat ($random(seed) & 3) pl.push_back(8'($random(seed)));
        exp_q.push_back(ACK_BYTE);
        send_pkt(pl);
        drain();
        cmp8("status after command", STAT_UNKNOWN, status);
    endtask

    task automatic query(input logic [7:0] st, input bit nak);
        exp_q.push_back(ACK_BYTE);
        exp_q.push_back(STATUS_PKT_LEN);
        exp_q.push_back(st);
        exp_q.push_back(st);
        send_pkt({CMD_STATUS_QRY});
        drain();
        put(nak ? NAK_BYTE : ACK_BYTE);
        repeat (3 * BIT_CLKS) @(negedge clk_sys);
    endtask

    // watchdog, several times the expected run length
    initial
    begin
        repeat (80000) @(posedge clk_sys);
        bad_count++;
        $display("watchdog expired");
        conclude();
    end

    initial
    begin
        seed = 32'h16d62742;
        bad_count = 0;
        tests_run = 0;
        use_spi = 1'b0;
        rst_n = 1'b0;
        do_reset();
        $display("test reset done");
        exp_q.push_back(ACK_BYTE);
        for (int k = 0; k < 3 && exp_q.size() != 0; k++)
        begin
            u_host.uart_byte(SYNC_BYTE);
            u_host.uart_byte(SYNC_BYTE);
            for (int n = 0; n < 40 * BIT_CLKS && exp_q.size() != 0; n++)
                @(negedge clk_sys);
        end
        drain();
        $display("test auto baud done");
        other_cmd();
        query(STAT_UNKNOWN, 1'b0);
        ping();
        query(STAT_SUCCESS, 1'b0);
        cmp8("lock to uart", 8'h01, {6'h00, lock});
        $display("test uart packets done");
        exp_q.push_back(NAK_BYTE);
        send_raw({MIN_PKT_LEN, 8'h21, CMD_PING});
        drain();
        exp_q.push_back(NAK_BYTE);
        send_raw({8'h02, ZERO_BYTE});
        drain();
        cmp8("status after nak", STAT_SUCCESS, status);
        $display("test bad packets done");
        use_spi = 1'b1;
        send_pkt({CMD_PING});
        cmp8("miso drive under uart lock", 8'h00, {7'h00, oe_seen});
        cmp8("lock kept", 8'h01, {6'h00, lock});
        $display("test spi ignored done");
        do_reset();
        ping();
        cmp8("lock to spi", 8'h02, {6'h00, lock});
        other_cmd();
        query(STAT_UNKNOWN, 1'b1);
        query(STAT_UNKNOWN, 1'b0);
        $display("test spi packets done");
        use_spi = 1'b0;
        u_host.uart_byte(SYNC_BYTE);
        u_host.uart_byte(SYNC_BYTE);
        repeat (60 * BIT_CLKS) @(negedge clk_sys);
        cmp8("lock stays spi", 8'h02, {6'h00, lock});
        $display("test uart ignored done");
        conclude();
    end
endmodule
